/* File: hw/fsw_map.svh */
/*
  Named constants of the fieldbus slave configuration and watchdog block:
  timing figures, baud table, pin roles, register offsets and resets.
  Assumes a single 50 MHz system clock.
*/
`ifndef FSW_MAP_SVH
`define FSW_MAP_SVH

`define CLK_HZ_DEF 50000000
`define CLK_PERIOD_NS 20
`define WD_TICK_NS 1000000
`define WD_TICK_CYCLES (`WD_TICK_NS / `CLK_PERIOD_NS)
`define SEARCH_BITS 16384
`define SEARCH_CNT_W 15
`define FACTOR_LONG_TICKS 4'hA

`define BAUD_IDX_W 4
`define BAUD_LAST 4'h8
`define BAUD_START_FAST 4'h0
`define BAUD_START_SLOW 4'h1
`define BAUD_0 12000000
`define BAUD_1 6000000
`define BAUD_2 3000000
`define BAUD_3 1500000
`define BAUD_4 500000
`define BAUD_5 187500
`define BAUD_6 93750
`define BAUD_7 19200
`define BAUD_8 9600
`define DIV_W 20

`define MULT_W 8
`define WD_CNT_W 16
`define SETTLE_DONE 3'h4

`define TS_W 7
`define TS_DIN 1
`define TS_CS 2
`define TS_CLK 3
`define TS_DOUT 4
`define TS_ACA 5
`define TS_MTYPE 6
`define TS_OE_SERIAL 7'h1C

`define REG_PARAM 8'h00
`define REG_STATUS 8'h04
`define REG_STRAPS 8'h08
`define PF_FACTOR 0
`define PF_MULT_A 8
`define PF_MULT_B 16
`define LANE_FACTOR 0
`define LANE_MULT_A 1
`define LANE_MULT_B 2
`define RST_MULT_A 8'h0A
`define RST_MULT_B 8'h0A

`endif

/* File: hw/fsw_pkg.sv */
/*
  Types and shared helpers of the configuration and watchdog block.
  Assumes fsw_map.svh for all figures.
*/
package fsw_pkg;
  `include "fsw_map.svh"

  typedef enum logic [0:0] {
    MODE_SEARCH = 1'b0,
    MODE_WATCH = 1'b1
  } wd_mode_t;

  typedef struct packed {
    wd_mode_t mode;
    logic [`BAUD_IDX_W-1:0] baud_idx;
    logic [2:0] settle;
    logic strap_done;
    logic fast_clk;
    logic serial_src;
    logic [`SEARCH_CNT_W-1:0] search_cnt;
    logic [3:0] ms_pre;
    logic [`WD_CNT_W-1:0] wd_cnt;
    logic factor_long;
    logic [`MULT_W-1:0] mult_a;
    logic [`MULT_W-1:0] mult_b;
    logic power_on;
    logic ack;
    logic [31:0] rdata;
    logic outputs_clear;
    logic wd_timeout;
    logic exchange;
    logic diag_err;
    logic announce;
    logic consistent;
    logic [`TS_W-1:0] station_addr;
    logic [2:0] ident_bits;
    logic mem_eeprom;
    logic aca;
    logic addr_permit;
    logic sm_din;
    logic [`TS_W-1:0] ts_out;
    logic [`TS_W-1:0] ts_oe;
  } fsw_state_t;

  // Cycles per bit for a baud index, never below one
  function automatic logic [`DIV_W-1:0] baud_div(
      input logic [`BAUD_IDX_W-1:0] idx, input int unsigned clk_hz);
    int unsigned baud;
    int unsigned d;
    case (idx)
      4'h0: baud = `BAUD_0;
      4'h1: baud = `BAUD_1;
      4'h2: baud = `BAUD_2;
      4'h3: baud = `BAUD_3;
      4'h4: baud = `BAUD_4;
      4'h5: baud = `BAUD_5;
      4'h6: baud = `BAUD_6;
      4'h7: baud = `BAUD_7;
      default: baud = `BAUD_8;
    endcase
    d = clk_hz / baud;
    if (d < 1) begin
      d = 1;
    end
    return `DIV_W'(d);
  endfunction

  // Watchdog reload in time-factor units
  function automatic logic [`WD_CNT_W-1:0] wd_load(
      input logic [`MULT_W-1:0] a, input logic [`MULT_W-1:0] b);
    return `WD_CNT_W'(a) * `WD_CNT_W'(b);
  endfunction
endpackage

/* File: hw/pin_sync.sv */
/*
  Three-stage input synchroniser; a change is taken once the second and
  third stages agree. Assumes inputs asynchronous to clk.
*/
`timescale 1ns/1ns
module pin_sync #(
  parameter int W = 1
) (
  input wire logic clk, // System clock
  input wire logic rstn, // Async reset, active low
  input wire logic [W-1:0] d, // Raw pin levels
  output logic [W-1:0] q // Filtered levels
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } sync_state_t;

  sync_state_t st_reg, st_next;

  always_comb begin
    st_next = st_reg;
    st_next.s1 = d;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    for (int i = 0; i < W; i++) begin
      if (st_reg.s2[i] == st_reg.s3[i]) begin
        st_next.q[i] = st_reg.s3[i];
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign q = st_reg.q;
endmodule

/* File: hw/tick_gen.sv */
/*
  Bit-time and watchdog time-base enables. Assumes clk at CLK_HZ and a
  restart pulse whenever the baud index changes.
*/
`timescale 1ns/1ns
module tick_gen
  import fsw_pkg::*;
#(
  parameter int unsigned CLK_HZ = `CLK_HZ_DEF,
  parameter int unsigned MS_CYCLES = `WD_TICK_CYCLES
) (
  input wire logic clk, // System clock
  input wire logic rstn, // Async reset, active low
  input wire logic [`BAUD_IDX_W-1:0] baud_idx, // Current baud
  input wire logic restart, // Restart both dividers
  output logic bit_tick, // One pulse per bit time
  output logic ms_tick // One pulse per base time unit
);
  typedef struct packed {
    logic [`DIV_W-1:0] bit_cnt;
    logic [`DIV_W-1:0] ms_cnt;
    logic bit_tick;
    logic ms_tick;
  } tick_state_t;

  tick_state_t st_reg, st_next;

  always_comb begin
    st_next = st_reg;
    st_next.bit_tick = 1'b0;
    st_next.ms_tick = 1'b0;
    if (restart) begin
      st_next.bit_cnt = '0;
      st_next.ms_cnt = '0;
    end else begin
      if (st_reg.bit_cnt >= baud_div(baud_idx, CLK_HZ) - 1'b1) begin
        st_next.bit_cnt = '0;
        st_next.bit_tick = 1'b1;
      end else begin
        st_next.bit_cnt = st_reg.bit_cnt + 1'b1;
      end
      if (st_reg.ms_cnt >= `DIV_W'(MS_CYCLES - 1)) begin
        st_next.ms_cnt = '0;
        st_next.ms_tick = 1'b1;
      end else begin
        st_next.ms_cnt = st_reg.ms_cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign bit_tick = st_reg.bit_tick;
  assign ms_tick = st_reg.ms_tick;
endmodule

/* File: hw/fieldbus_slave_config_watchdog.sv */
/*
  Strap decoding, status outputs and bus watchdog of a fieldbus slave.
  Assumes telegram, data-exchange and serial-memory controller signals
  come from logic on clk; straps and pins are asynchronous.
*/
// Chosen here: register access over Wishbone and the register addresses.
`timescale 1ns/1ns
module fieldbus_slave_config_watchdog
  import fsw_pkg::*;
#(
  parameter int unsigned CLK_HZ = `CLK_HZ_DEF,
  parameter int unsigned MS_CYCLES = `WD_TICK_CYCLES,
  parameter int DIAG_W = 8
) (
  input wire logic clk, // System clock, 50 MHz
  input wire logic rstn, // Async reset, active low
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Wishbone write
  input wire logic [7:0] wb_adr_i, // Wishbone byte address
  input wire logic [3:0] wb_sel_i, // Wishbone byte enables
  input wire logic [31:0] wb_dat_i, // Wishbone write data
  output logic [31:0] wb_dat_o, // Wishbone read data
  output logic wb_ack_o, // Wishbone acknowledge
  input wire logic clock_rate_select, // Strap: high for fast clock
  input wire logic consistency_enable, // Strap: consistent ports
  input wire logic param_source_select, // Strap: serial memory
  input wire logic [6:0] station_address_pins_i, // Address pins in
  output logic [6:0] station_address_pins_o, // Address pins out
  output logic [6:0] station_address_pins_oe, // Address pins enable
  input wire logic ident_diag_pin_low, // Ident or diagnosis pin
  input wire logic ident_diag_pin_mid, // Ident or diagnosis pin
  input wire logic ident_diag_pin_high, // Ident or diagnosis pin
  input wire logic [DIAG_W-1:0] diag_port_n, // Diagnosis inputs
  input wire logic frame_ok, // Complete error-free frame
  input wire logic short_frame, // Short token frame seen
  input wire logic telegram_valid, // Valid telegram for us
  input wire logic data_exchange, // Protocol in exchange state
  input wire logic access_pending, // Consistent access coming
  input wire logic addr_lock_bit, // Stored address lock flag
  input wire logic addr_written, // Address write finished
  input wire logic sm_select_drv, // Memory chip select level
  input wire logic sm_clock_drv, // Memory clock level
  input wire logic sm_dout_drv, // Memory data out level
  output logic serial_mem_data_in, // Memory data in level
  output logic [6:0] station_address, // Parallel address
  output logic [2:0] ident_bits, // Parallel ident bits
  output logic param_from_serial, // Serial parameter source
  output logic memory_type_select, // High for EEPROM memory type
  output logic fast_clock, // Fast clock latched
  output logic port_consistent, // Consistent port mode
  output logic consistency_announce, // Consistent access ahead
  output logic addr_write_permit, // Address overwrite allowed
  output logic diag_error_indicator, // Diagnostic error
  output logic exchange_state_indicator, // Data exchange state
  output logic outputs_clear, // Clear all port outputs
  output logic wd_timeout, // Watchdog expired pulse
  output logic search_active, // Baud search running
  output logic [3:0] baud_index // Current baud index
);
  localparam int SW = 3 + `TS_W + 3 + DIAG_W;

  fsw_state_t st_reg, st_next;
  logic [SW-1:0] sync_q;
  logic s_fast, s_cons, s_serial;
  logic [6:0] s_ts;
  logic [2:0] s_ident;
  logic [DIAG_W-1:0] s_diag;
  logic bit_tick, ms_tick, tick_restart;
  logic bus_req, bus_wr;
  logic [`BAUD_IDX_W-1:0] start_idx;

  pin_sync #(.W(SW)) u_sync (
    .clk(clk),
    .rstn(rstn),
    .d({clock_rate_select, consistency_enable, param_source_select,
        station_address_pins_i, ident_diag_pin_high, ident_diag_pin_mid,
        ident_diag_pin_low, diag_port_n}),
    .q(sync_q)
  );

  assign {s_fast, s_cons, s_serial, s_ts, s_ident, s_diag} = sync_q;

  tick_gen #(.CLK_HZ(CLK_HZ), .MS_CYCLES(MS_CYCLES)) u_tick (
    .clk(clk),
    .rstn(rstn),
    .baud_idx(st_reg.baud_idx),
    .restart(tick_restart),
    .bit_tick(bit_tick),
    .ms_tick(ms_tick)
  );

  assign tick_restart = st_next.baud_idx != st_reg.baud_idx ||
                        st_next.mode != st_reg.mode;
  assign bus_req = wb_cyc_i && wb_stb_i && !st_reg.ack;
  assign bus_wr = bus_req && wb_we_i;
  assign start_idx = st_reg.fast_clk ? `BAUD_START_FAST
                                     : `BAUD_START_SLOW;

  always_comb begin
    st_next = st_reg;
    st_next.outputs_clear = 1'b0;
    st_next.wd_timeout = 1'b0;
    st_next.ack = bus_req;

    // ****************************************
    // Strap capture after reset release
    // ****************************************
    if (!st_reg.strap_done) begin
      if (st_reg.settle == `SETTLE_DONE) begin
        st_next.strap_done = 1'b1;
        st_next.fast_clk = s_fast;
        st_next.serial_src = s_serial;
        st_next.baud_idx = s_fast ? `BAUD_START_FAST
                                  : `BAUD_START_SLOW;
        st_next.search_cnt = '0;
      end else begin
        st_next.settle = st_reg.settle + 1'b1;
      end
    end

    // ****************************************
    // Pin roles
    // ****************************************
    st_next.consistent = s_cons;
    st_next.announce = s_cons && access_pending;
    if (st_reg.serial_src) begin
      st_next.station_addr = '0;
      st_next.ident_bits = '0;
      st_next.sm_din = s_ts[`TS_DIN];
      st_next.aca = s_ts[`TS_ACA];
      st_next.mem_eeprom = s_ts[`TS_MTYPE];
      st_next.ts_oe = `TS_OE_SERIAL;
      st_next.ts_out = '0;
      st_next.ts_out[`TS_CS] = sm_select_drv;
      st_next.ts_out[`TS_CLK] = sm_clock_drv;
      st_next.ts_out[`TS_DOUT] = sm_dout_drv;
      st_next.diag_err = !(&s_diag) || !(&s_ident);
    end else begin
      st_next.station_addr = s_ts;
      st_next.ident_bits = s_ident;
      st_next.sm_din = 1'b0;
      st_next.aca = 1'b0;
      st_next.mem_eeprom = 1'b0;
      st_next.ts_oe = '0;
      st_next.ts_out = '0;
      st_next.diag_err = !(&s_diag);
    end

    // ****************************************
    // Address overwrite permission
    // ****************************************
    if (addr_written) begin
      st_next.power_on = 1'b0;
    end
    st_next.addr_permit = st_next.mem_eeprom && (st_reg.power_on ||
        st_next.aca || !addr_lock_bit);

    // ****************************************
    // Baud search and watchdog
    // ****************************************
    if (st_reg.strap_done) begin
      unique case (st_reg.mode)
        MODE_SEARCH: begin
          if (frame_ok) begin
            st_next.mode = MODE_WATCH;
            st_next.wd_cnt = wd_load(st_reg.mult_a, st_reg.mult_b);
            st_next.ms_pre = '0;
          end else if (short_frame) begin
            st_next.search_cnt = '0;
          end else if (bit_tick) begin
            if (st_reg.search_cnt ==
                `SEARCH_CNT_W'(`SEARCH_BITS - 1)) begin
              st_next.search_cnt = '0;
              st_next.baud_idx = (st_reg.baud_idx == `BAUD_LAST) ?
                                 start_idx : st_reg.baud_idx + 1'b1;
            end else begin
              st_next.search_cnt = st_reg.search_cnt + 1'b1;
            end
          end
        end
        MODE_WATCH: begin
          if (telegram_valid) begin
            st_next.wd_cnt = wd_load(st_reg.mult_a, st_reg.mult_b);
            st_next.ms_pre = '0;
          end else if (ms_tick) begin
            if (st_reg.factor_long &&
                st_reg.ms_pre != `FACTOR_LONG_TICKS - 1'b1) begin
              st_next.ms_pre = st_reg.ms_pre + 1'b1;
            end else begin
              st_next.ms_pre = '0;
              if (st_reg.wd_cnt <= `WD_CNT_W'(1)) begin
                st_next.mode = MODE_SEARCH;
                st_next.outputs_clear = 1'b1;
                st_next.wd_timeout = 1'b1;
                st_next.baud_idx = start_idx;
                st_next.search_cnt = '0;
                st_next.wd_cnt = '0;
              end else begin
                st_next.wd_cnt = st_reg.wd_cnt - 1'b1;
              end
            end
          end
        end
      endcase
    end
    st_next.exchange = data_exchange && st_next.mode == MODE_WATCH &&
                       !st_next.wd_timeout;
    if (st_next.wd_timeout) begin
      st_next.announce = 1'b0;
    end

    // ****************************************
    // Register access
    // ****************************************
    if (bus_wr && wb_adr_i == `REG_PARAM) begin
      if (wb_sel_i[`LANE_FACTOR]) begin
        st_next.factor_long = wb_dat_i[`PF_FACTOR];
      end
      if (wb_sel_i[`LANE_MULT_A]) begin
        st_next.mult_a = wb_dat_i[`PF_MULT_A +: `MULT_W];
      end
      if (wb_sel_i[`LANE_MULT_B]) begin
        st_next.mult_b = wb_dat_i[`PF_MULT_B +: `MULT_W];
      end
    end
    st_next.rdata = '0;
    if (bus_req && !wb_we_i) begin
      unique case (wb_adr_i)
        `REG_PARAM: st_next.rdata = {8'h00, st_reg.mult_b, st_reg.mult_a,
                                     7'h00, st_reg.factor_long};
        `REG_STATUS: st_next.rdata = {6'h00, st_reg.diag_err,
                                      st_reg.exchange, st_reg.wd_cnt,
                                      st_reg.baud_idx, 3'h0,
                                      st_reg.mode};
        `REG_STRAPS: st_next.rdata = {18'h00000, st_reg.addr_permit,
                                      st_reg.consistent, st_reg.aca,
                                      st_reg.mem_eeprom, st_reg.serial_src,
                                      st_reg.fast_clk, 1'b0,
                                      st_reg.station_addr};
        default: st_next.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= '0;
      st_reg.power_on <= 1'b1;
      st_reg.mult_a <= `RST_MULT_A;
      st_reg.mult_b <= `RST_MULT_B;
      st_reg.baud_idx <= `BAUD_START_SLOW;
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign wb_dat_o = st_reg.rdata;
  assign wb_ack_o = st_reg.ack;
  assign station_address_pins_o = st_reg.ts_out;
  assign station_address_pins_oe = st_reg.ts_oe;
  assign serial_mem_data_in = st_reg.sm_din;
  assign station_address = st_reg.station_addr;
  assign ident_bits = st_reg.ident_bits;
  assign param_from_serial = st_reg.serial_src;
  assign memory_type_select = st_reg.mem_eeprom;
  assign fast_clock = st_reg.fast_clk;
  assign port_consistent = st_reg.consistent;
  assign consistency_announce = st_reg.announce;
  assign addr_write_permit = st_reg.addr_permit;
  assign diag_error_indicator = st_reg.diag_err;
  assign exchange_state_indicator = st_reg.exchange;
  assign outputs_clear = st_reg.outputs_clear;
  assign wd_timeout = st_reg.wd_timeout;
  assign search_active = st_reg.mode == MODE_SEARCH;
  assign baud_index = st_reg.baud_idx;
endmodule

/* File: bench/fsw_chk.sv */
/*
  Port checks of the configuration and watchdog block.
  Assumes bind into the top module, one clock, async low reset.
*/
`timescale 1ns/1ns
module fsw_chk #(
  parameter int DIAG_W = 8
) (
  input wire logic clk, // Clock
  input wire logic rstn, // Reset, low
  input wire logic [DIAG_W-1:0] diag_port_n, // Diag inputs
  input wire logic [6:0] station_address_pins_i, // Pins
  input wire logic data_exchange, // Exchange level
  input wire logic access_pending, // Access ahead
  input wire logic wd_timeout, // Timeout
  input wire logic outputs_clear, // Clear
  input wire logic search_active, // Search
  input wire logic [3:0] baud_index, // Baud
  input wire logic fast_clock, // Fast strap
  input wire logic param_from_serial, // Serial source
  input wire logic addr_write_permit, // Permit
  input wire logic diag_error_indicator, // Diag error
  input wire logic exchange_state_indicator, // Exchange
  input wire logic consistency_announce // Announce
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  property p_diag;
    (!(&diag_port_n) && $stable(diag_port_n))[*8] |-> diag_error_indicator;
  endproperty
  a_diag: assert property (p_diag)
    else $error("diag error missing");
  property p_exch;
    exchange_state_indicator |-> $past(data_exchange) &&
      (!search_active || $past(!search_active));
  endproperty
  a_exch: assert property (p_exch)
    else $error("exchange without cause");
  property p_clear;
    wd_timeout |-> outputs_clear && search_active && !consistency_announce;
  endproperty
  a_clear: assert property (p_clear)
    else $error("timeout without clear");
  property p_pulse;
    wd_timeout |=> !wd_timeout && !outputs_clear && !exchange_state_indicator;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("timeout pulse too long");
  property p_start;
    wd_timeout |-> baud_index == (fast_clock ? 4'h0 : 4'h1);
  endproperty
  a_start: assert property (p_start)
    else $error("search not from top rate");
  property p_rate;
    baud_index <= 4'h8 && (fast_clock || baud_index != 4'h0);
  endproperty
  a_rate: assert property (p_rate)
    else $error("baud index out of range");
  property p_announce;
    consistency_announce |-> $past(access_pending);
  endproperty
  a_announce: assert property (p_announce)
    else $error("announce without access");
  property p_permit;
    (param_from_serial && !station_address_pins_i[6] &&
      $stable(station_address_pins_i))[*8] |-> !addr_write_permit;
  endproperty
  a_permit: assert property (p_permit)
    else $error("permit with shift register");
  c_tmo: cover property (wd_timeout);
  c_exch: cover property (exchange_state_indicator);
  c_watch: cover property ($fell(search_active));
endmodule

/* File: bench/fsw_master_model.sv */
/*
  Bus master model: frame and telegram events, exchange level.
  Assumes tasks are called from the bench.
*/
`timescale 1ns/1ns
module fsw_master_model (
  input wire logic clk, // Clock
  output logic frame_ok, // Good frame
  output logic short_frame, // Token frame
  output logic telegram_valid, // Telegram
  output logic data_exchange // Exchange level
);
  initial begin
    {frame_ok, short_frame, telegram_valid, data_exchange} = 4'h0;
  end
  // Kind 0 frame, 1 short frame, 2 telegram
  task automatic send(input int kind);
    @(posedge clk);
    frame_ok <= (kind == 0);
    short_frame <= (kind == 1);
    telegram_valid <= (kind == 2);
    @(posedge clk);
    {frame_ok, short_frame, telegram_valid} <= 3'h0;
  endtask
  task automatic xchg(input logic v);
    @(posedge clk);
    data_exchange <= v;
  endtask
  function automatic logic [31:0] prm(input logic f,
      input logic [7:0] a, input logic [7:0] b);
    logic [7:0] x;
    x = (a == 8'h00 || (a == 8'h01 && b == 8'h01)) ? 8'h02 : a;
    return {8'h00, (b == 8'h00) ? 8'h02 : b, x, 7'h00, f};
  endfunction
endmodule

/* File: bench/fieldbus_slave_config_watchdog_tb_top.sv */
/*
  Self-checking bench of the configuration and watchdog block.
  Assumes a shortened time base and bit rate through parameters.
*/
`timescale 1ns/1ns
module fieldbus_slave_config_watchdog_tb_top;
  localparam int unsigned MS = 10;
  logic clk = 1'b0, rstn = 1'b0;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00, diag_port_n = 8'hFF;
  logic [3:0] wb_sel_i = 4'h0, baud_index;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
  logic clock_rate_select = 1'b1, consistency_enable = 1'b0;
  logic param_source_select = 1'b0, ident_diag_pin_low = 1'b1;
  logic ident_diag_pin_mid = 1'b1, ident_diag_pin_high = 1'b1;
  logic [6:0] station_address_pins_i = 7'h00, station_address;
  logic [6:0] station_address_pins_o, station_address_pins_oe;
  logic access_pending = 1'b0, addr_lock_bit = 1'b0, addr_written = 1'b0;
  logic sm_select_drv = 1'b0, sm_clock_drv = 1'b0, sm_dout_drv = 1'b0;
  logic frame_ok, short_frame, telegram_valid, data_exchange, pon;
  logic wb_ack_o, serial_mem_data_in, param_from_serial, fast_clock;
  logic [2:0] ident_bits;
  logic memory_type_select, port_consistent, consistency_announce;
  logic addr_write_permit, diag_error_indicator, exchange_state_indicator;
  logic outputs_clear, wd_timeout, search_active;
  int err_count = 0, cmp_count = 0, seed = 32'he9f0, tmo = 0;
  fieldbus_slave_config_watchdog #(.CLK_HZ(120000), .MS_CYCLES(MS)) dut_u (.*);
  fsw_master_model bus_u (.*);
  always #10 clk = ~clk;
  always @(posedge clk) if (wd_timeout === 1'b1) tmo++;
  initial begin
    repeat (60000) @(posedge clk);
    err_count++;
    end_sim;
  end
  //**************************************************************
  // Tasks and expectations
  //**************************************************************
  task automatic end_sim;
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_win(input int got, input int lo, input int hi);
    cmp_count++;
    if (got < lo || got > hi) begin
      err_count++;
      $display("Error %0t: count %0d not in %0d..%0d", $time, got, lo, hi);
    end
  endtask
  function automatic logic exp_diag(input logic ser);
    return ~&diag_port_n | (ser & ~&{ident_diag_pin_high,
      ident_diag_pin_mid, ident_diag_pin_low});
  endfunction
  function automatic logic [31:0] exp_param(input logic [31:0] d,
      input logic [3:0] s);
    return {8'h00, s[2] ? d[23:16] : 8'h0A, s[1] ? d[15:8] : 8'h0A,
      7'h00, s[0] & d[0]};
  endfunction
  function automatic logic exp_permit();
    return station_address_pins_i[6] &
      (pon | station_address_pins_i[5] | ~addr_lock_bit);
  endfunction
  task automatic wb(input logic we, input logic [7:0] a, input logic [3:0] s,
      input logic [31:0] d, output logic [31:0] r);
    int n = 0;
    @(posedge clk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i} <= {2'b11, we, s};
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    r = wb_dat_o;
    if (n >= 50) err_count++;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask
  task automatic do_reset(input logic fast, input logic ser);
    @(posedge clk);
    {rstn, clock_rate_select, param_source_select} <= {1'b0, fast, ser};
    {ident_diag_pin_high, ident_diag_pin_mid, ident_diag_pin_low} <= 3'h7;
    station_address_pins_i <= 7'h00;
    pon = 1'b1;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    repeat (8) @(posedge clk);
  endtask
  task automatic rand_pins(input logic ser);
    logic [31:0] r;
    r = $random(seed);
    @(posedge clk);
    diag_port_n <= r[0] ? 8'hFF : r[15:8];
    station_address_pins_i <= r[22:16];
    {ident_diag_pin_high, ident_diag_pin_mid, ident_diag_pin_low} <=
      r[3:1] | {3{r[4]}};
    {sm_dout_drv, sm_clock_drv, sm_select_drv} <= r[7:5];
    {addr_lock_bit, access_pending, consistency_enable} <= r[26:24];
    repeat (10) @(posedge clk);
    chk(diag_error_indicator, exp_diag(ser));
    chk({param_from_serial, port_consistent}, {ser, r[24]});
    if (!ser) begin
      chk({ident_bits, station_address},
        {r[3:1] | {3{r[4]}}, r[22:16]});
    end else begin
      chk({station_address, serial_mem_data_in}, {7'h00, r[17]});
      chk(memory_type_select, r[22]);
      chk(station_address_pins_oe, 7'h1C);
      chk(station_address_pins_o, {2'b00, r[7:5], 2'b00});
      chk(addr_write_permit, exp_permit());
    end
    if (r[27]) begin
      addr_written <= 1'b1;
      @(posedge clk);
      addr_written <= 1'b0;
      pon = 1'b0;
    end
  endtask
  task automatic watch(input logic f, input logic [7:0] a, input logic [7:0] b);
    int n = 0;
    int t;
    int k;
    logic [31:0] w;
    w = bus_u.prm(f, a, b);
    t = (w[0] ? 10 : 1) * w[15:8] * w[23:16] * MS;
    wb(1'b1, 8'h00, 4'hF, w, q);
    bus_u.send(0);
    @(posedge clk);
    chk(search_active, 1'b0);
    bus_u.xchg(1'b1);
    k = tmo;
    repeat (3) begin
      repeat (t / 2) @(posedge clk);
      bus_u.send(2);
    end
    repeat (2) @(posedge clk);
    chk({exchange_state_indicator, tmo[7:0]}, {1'b1, k[7:0]});
    while (wd_timeout !== 1'b1 && n < 2 * t) begin
      @(posedge clk);
      n++;
    end
    chk_win(n + 2, t - (w[0] ? 10 : 1) * MS, t + 4);
    repeat (2) @(posedge clk);
    chk({exchange_state_indicator, search_active, baud_index},
      6'h10);
    bus_u.xchg(1'b0);
  endtask
  initial begin
    int n = 0;
    logic [31:0] r, d;
    do_reset(1'b1, 1'b0);
    chk({fast_clock, search_active, baud_index}, 6'h30);
    wb(1'b0, 8'h00, 4'hF, 32'h0, q);
    chk(q, 32'h000A0A00);
    wb(1'b0, 8'h0C, 4'hF, 32'h0, q);
    chk(q, 32'h0);
    wb(1'b1, 8'h04, 4'hF, 32'hFFFFFFFF, q);
    wb(1'b0, 8'h04, 4'hF, 32'h0, q);
    chk(q[7:0], 8'h00);
    r = $random(seed);
    d = bus_u.prm(r[0], r[15:8], r[23:16]);
    wb(1'b1, 8'h00, r[27:24], d, q);
    wb(1'b0, 8'h00, 4'hF, 32'h0, q);
    chk(q, exp_param(d, r[27:24]));
    $display("test reset done");
    repeat (8000) @(posedge clk);
    bus_u.send(1);
    while (baud_index === 4'h0 && n < 20000) begin
      @(posedge clk);
      n++;
    end
    chk_win(n, 16376, 16392);
    chk(baud_index, 4'h1);
    $display("test search done");
    repeat (12) rand_pins(1'b0);
    $display("test parallel done");
    watch(1'b0, 8'h02, 8'h03);
    watch(1'b1, 8'h02, 8'h01);
    $display("test watchdog done");
    do_reset(1'b0, 1'b1);
    chk({fast_clock, baud_index}, 5'h01);
    wb(1'b0, 8'h08, 4'hF, 32'h0, q);
    chk(q, {19'h00000, consistency_enable, 12'h200});
    repeat (16) rand_pins(1'b1);
    $display("test serial done");
    end_sim;
  end
endmodule
bind fieldbus_slave_config_watchdog fsw_chk #(.DIAG_W(DIAG_W)) chk_u (.*);
